// File: scc_pkg.sv
// Shared constants for the clock tree control block
package scc_pkg;
  // Reset configuration word layout
  localparam int          CFG_W         = 32;
  localparam int          LOCALBUS_CLOCK_DOUBLE_BIT      = 0;
  localparam int          MEMORY_CLOCK_DOUBLE_BIT     = 1;
  localparam int          SYSTEM_PLL_FACTOR_LSB      = 4;
  localparam int          SYSTEM_PLL_FACTOR_W        = 4;
  localparam int          CORE_LSB      = 8;
  localparam int          CORE_W        = 7;
  localparam logic [CFG_W-1:0] HARD_CFG_DEFAULT = 32'h0000_0240;
  // System PLL factor codes
  localparam logic [3:0]  SYSTEM_PLL_FACTOR_MIN      = 4'h2;
  localparam logic [3:0]  SYSTEM_PLL_FACTOR_MAX      = 4'h6;
  // Core PLL field pieces
  localparam logic [1:0]  CORE_VCO_RSVD = 2'h3;
  localparam logic [3:0]  CORE_RATIO_0  = 4'h0;
  localparam logic [3:0]  CORE_RATIO_1  = 4'h1;
  localparam logic [3:0]  CORE_RATIO_2  = 4'h2;
  localparam logic [3:0]  CORE_RATIO_3  = 4'h3;
  localparam logic [2:0]  CORE_MULT_X2_1 = 3'h2;
  // Peripheral clock ratio codes
  localparam logic [1:0]  RATIO_OFF     = 2'h0;
  localparam logic [1:0]  RATIO_FULL    = 2'h1;
  localparam logic [1:0]  RATIO_HALF    = 2'h2;
  localparam logic [1:0]  RATIO_THIRD   = 2'h3;
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  localparam logic [1:0]  CNT_HALF      = 2'h1;
  localparam logic [1:0]  CNT_THIRD     = 2'h2;
  // Local bus divider select codes and half periods less one in internal ticks
  localparam logic [1:0]  LBDIV_2       = 2'h0;
  localparam logic [1:0]  LBDIV_4       = 2'h1;
  localparam logic [1:0]  LBDIV_8       = 2'h2;
  localparam logic [2:0]  LBHALF_2      = 3'h0;
  localparam logic [2:0]  LBHALF_4      = 3'h1;
  localparam logic [2:0]  LBHALF_8      = 3'h3;
  localparam int          N_UNITS       = 5;
  localparam int          PCIDMA_UNIT   = 4;
endpackage

// File: scc_ratio_gate.sv
// Glitch-free ratio gate producing one peripheral clock enable
`timescale 1ns/1ns
module scc_ratio_gate #(
  parameter bit FULL_ONLY = 1'b0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic         i_tick,
  input  wire logic [1:0]   i_ratio,
  output logic              o_en
);
  import scc_pkg::*;

  logic [1:0] ratio;
  logic [1:0] cnt;
  logic       en;
  logic [1:0] next_ratio;
  logic [1:0] next_cnt;
  logic       next_en;
  logic [1:0] req;

  always_comb begin
    req        = i_ratio;
    next_ratio = ratio;
    next_cnt   = cnt;
    next_en    = 1'b0;
    if (FULL_ONLY && (i_ratio != RATIO_OFF)) begin
      req = RATIO_FULL;
    end
    if (i_tick) begin
      // New ratio is taken only at a period boundary, so no pulse is cut short
      if (cnt == CNT_ZERO) begin
        next_ratio = req;
        next_en    = (req != RATIO_OFF);
        case (req)
          RATIO_HALF:  next_cnt = CNT_HALF;
          RATIO_THIRD: next_cnt = CNT_THIRD;
          default:     next_cnt = CNT_ZERO;
        endcase
      end else begin
        next_cnt = cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ratio <= RATIO_FULL;
      cnt   <= CNT_ZERO;
      en    <= 1'b0;
    end else if (i_ce) begin
      ratio <= next_ratio;
      cnt   <= next_cnt;
      en    <= next_en;
    end
  end

  assign o_en = en;
endmodule

// File: scc_top.sv
// Clock tree control: source select, PLL decode, dividers and unit gates
`timescale 1ns/1ns
module scc_top
  import scc_pkg::*;
#(
  parameter int                   N_PCI_OUT = 5,
  parameter logic [CFG_W-1:0]     HARD_CFG  = HARD_CFG_DEFAULT
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  input  wire logic                  I_HOST_MODE,
  input  wire logic                  I_HOST_INPUT_CLOCK,
  input  wire logic                  I_AGENT_INPUT_CLOCK,
  input  wire logic                  I_INPUT_HALVING_SELECT,
  input  wire logic [N_PCI_OUT-1:0]  I_PCI_OUT_ENABLE,
  input  wire logic                  I_USE_HARD_CFG,
  input  wire logic [CFG_W-1:0]      I_RESET_CONFIG_LOW,
  input  wire logic [1:0]            I_LOCALBUS_DIVIDER_FIELD,
  input  wire logic [2*N_UNITS-1:0]  I_UNIT_RATIO,
  output logic                       O_SYNC_CLOCK_OUT,
  output logic [N_PCI_OUT-1:0]       O_PCI_CLOCK_OUTPUTS,
  output logic                       O_CFG_LOADED,
  output logic [3:0]                 O_SYSTEM_BUS_MULT,
  output logic                       O_SYSTEM_PLL_RESERVED,
  output logic [2:0]                 O_CORE_MULT_X2,
  output logic                       O_CORE_PLL_BYPASS,
  output logic                       O_CORE_PLL_RESERVED,
  output logic                       O_MEMORY_CLOCK_DOUBLE,
  output logic                       O_LOCALBUS_CLOCK_DOUBLE,
  output logic                       O_SYSTEM_BUS_TICK,
  output logic                       O_MEMORY_INTERNAL_TICK,
  output logic                       O_MEMORY_BUS_CLOCK,
  output logic                       O_MEMORY_BUS_CLOCK_N,
  output logic [1:0]                 O_LOCALBUS_CLOCK_OUTPUTS,
  output logic [N_UNITS-1:0]         O_UNIT_CLOCK_EN
);
  import scc_pkg::*;

  if (N_PCI_OUT < 1 || N_PCI_OUT > 8) begin : g_bad_n
    $error("N_PCI_OUT must lie in 1..8");
  end

  // Pin synchronisers: mode, host clock, agent clock, halving select
  logic [3:0]             pin_s1;
  logic [3:0]             pin_s2;
  logic                   prim_d;
  logic                   half_q;
  logic                   sync_q;
  logic [N_PCI_OUT-1:0]   pci_en;
  logic [N_PCI_OUT-1:0]   pci_q;
  logic [CFG_W-1:0]       cfg;
  logic                   loaded;
  logic                   phase;
  logic                   mem_q;
  logic                   mem_tick_q;
  logic [2:0]             lb_cnt;
  logic [2:0]             lb_half;
  logic                   lb_q;

  logic                   host_mode;
  logic                   halve_sel;
  logic                   prim;
  logic                   next_half_q;
  logic                   next_sync_q;
  logic [N_PCI_OUT-1:0]   next_pci_en;
  logic [N_PCI_OUT-1:0]   next_pci_q;
  logic [CFG_W-1:0]       next_cfg;
  logic                   next_loaded;
  logic                   next_phase;
  logic                   next_mem_q;
  logic                   next_mem_tick_q;
  logic [2:0]             next_lb_cnt;
  logic [2:0]             next_lb_half;
  logic                   next_lb_q;
  logic [3:0]             system_pll_factor;
  logic [1:0]             core_vco;
  logic [3:0]             core_ratio;
  logic                   core_half;
  logic                   system_pll_factor_ok;
  logic                   csb_tick;
  logic                   mem_tick;
  logic                   lb_tick;
  logic [2:0]             lb_half_req;

  assign host_mode = pin_s2[0];
  assign halve_sel = pin_s2[3];
  // Agent mode ignores the host clock entirely
  assign prim      = host_mode ? pin_s2[1] : pin_s2[2];

  // Source select, halver and PCI output gating
  always_comb begin
    next_half_q = half_q;
    next_pci_en = pci_en;
    if (prim && !prim_d) begin
      next_half_q = ~half_q;
    end
    next_sync_q = halve_sel ? prim : half_q;
    // Enables switch only while sync clock is low, so no runt pulse appears
    if (!sync_q) begin
      next_pci_en = I_PCI_OUT_ENABLE;
    end
    next_pci_q = {N_PCI_OUT{sync_q}} & pci_en;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      prim_d <= 1'b0;
      half_q <= 1'b0;
      sync_q <= 1'b0;
      pci_en <= '0;
      pci_q  <= '0;
    end else if (I_CE) begin
      pin_s1 <= {I_INPUT_HALVING_SELECT, I_AGENT_INPUT_CLOCK, I_HOST_INPUT_CLOCK, I_HOST_MODE};
      pin_s2 <= pin_s1;
      prim_d <= prim;
      half_q <= next_half_q;
      sync_q <= next_sync_q;
      pci_en <= next_pci_en;
      pci_q  <= next_pci_q;
    end
  end

  // Configuration word capture: once, on the first enabled edge after reset
  always_comb begin
    next_cfg    = cfg;
    next_loaded = loaded;
    if (!loaded) begin
      next_cfg    = I_USE_HARD_CFG ? HARD_CFG : I_RESET_CONFIG_LOW;
      next_loaded = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cfg    <= '0;
      loaded <= 1'b0;
    end else if (I_CE) begin
      cfg    <= next_cfg;
      loaded <= next_loaded;
    end
  end

  // Field decode; core field bit 0 is the least significant, at CORE_LSB
  assign system_pll_factor       = cfg[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W];
  assign core_vco   = cfg[CORE_LSB+5 +: 2];
  assign core_ratio = cfg[CORE_LSB+1 +: 4];
  assign core_half  = cfg[CORE_LSB];
  assign system_pll_factor_ok    = (system_pll_factor >= SYSTEM_PLL_FACTOR_MIN) && (system_pll_factor <= SYSTEM_PLL_FACTOR_MAX);

  always_comb begin
    O_SYSTEM_PLL_RESERVED = !system_pll_factor_ok;
    O_SYSTEM_BUS_MULT     = 4'h0;
    if (system_pll_factor_ok) begin
      // Halving select low means sync in runs at half the primary clock
      O_SYSTEM_BUS_MULT = halve_sel ? system_pll_factor : 4'(system_pll_factor << 1);
    end
    O_CORE_PLL_BYPASS   = (core_ratio == CORE_RATIO_0) && !core_half;
    O_CORE_PLL_RESERVED = 1'b0;
    O_CORE_MULT_X2      = CORE_MULT_X2_1;
    case (core_ratio)
      CORE_RATIO_0: O_CORE_PLL_RESERVED = core_half;
      CORE_RATIO_1, CORE_RATIO_2:
        O_CORE_MULT_X2 = {core_ratio[1:0], core_half};
      CORE_RATIO_3: begin
        O_CORE_MULT_X2      = {core_ratio[1:0], 1'b0};
        O_CORE_PLL_RESERVED = core_half;
      end
      default: O_CORE_PLL_RESERVED = 1'b1;
    endcase
    if (!O_CORE_PLL_BYPASS && core_vco == CORE_VCO_RSVD) begin
      O_CORE_PLL_RESERVED = 1'b1;
    end
  end

  // Time-scaled model: system bus tick every second cycle, doubled domains every cycle
  assign csb_tick = phase;
  assign mem_tick = cfg[MEMORY_CLOCK_DOUBLE_BIT] ? 1'b1 : csb_tick;
  assign lb_tick  = cfg[LOCALBUS_CLOCK_DOUBLE_BIT] ? 1'b1 : csb_tick;

  always_comb begin
    case (I_LOCALBUS_DIVIDER_FIELD)
      LBDIV_4: lb_half_req = LBHALF_4;
      LBDIV_8: lb_half_req = LBHALF_8;
      default: lb_half_req = LBHALF_2;
    endcase
    next_phase      = ~phase;
    next_mem_tick_q = mem_tick;
    next_mem_q      = mem_tick ? ~mem_q : mem_q;
    next_lb_cnt     = lb_cnt;
    next_lb_half    = lb_half;
    next_lb_q       = lb_q;
    if (lb_tick) begin
      if (lb_cnt >= lb_half) begin
        next_lb_cnt = 3'h0;
        next_lb_q   = ~lb_q;
        // Divider change taken only at a falling edge, which ends a full period
        if (lb_q) begin
          next_lb_half = lb_half_req;
        end
      end else begin
        next_lb_cnt = lb_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      phase      <= 1'b0;
      mem_q      <= 1'b0;
      mem_tick_q <= 1'b0;
      lb_cnt     <= 3'h0;
      lb_half    <= LBHALF_2;
      lb_q       <= 1'b0;
    end else if (I_CE) begin
      phase      <= next_phase;
      mem_q      <= next_mem_q;
      mem_tick_q <= next_mem_tick_q;
      lb_cnt     <= next_lb_cnt;
      lb_half    <= next_lb_half;
      lb_q       <= next_lb_q;
    end
  end

  // Peripheral unit gates; last unit is the full-rate-only PCI/DMA complex
  for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
    scc_ratio_gate #(
      .FULL_ONLY (u == PCIDMA_UNIT)
    ) u_gate (
      .i_clk   (I_CLOCK),
      .i_rst   (I_RST),
      .i_ce    (I_CE),
      .i_tick  (csb_tick),
      .i_ratio (I_UNIT_RATIO[2*u +: 2]),
      .o_en    (O_UNIT_CLOCK_EN[u])
    );
  end

  assign O_SYNC_CLOCK_OUT         = sync_q;
  assign O_PCI_CLOCK_OUTPUTS      = pci_q;
  assign O_CFG_LOADED             = loaded;
  assign O_MEMORY_CLOCK_DOUBLE    = cfg[MEMORY_CLOCK_DOUBLE_BIT];
  assign O_LOCALBUS_CLOCK_DOUBLE  = cfg[LOCALBUS_CLOCK_DOUBLE_BIT];
  assign O_SYSTEM_BUS_TICK        = phase;
  assign O_MEMORY_INTERNAL_TICK   = mem_tick_q;
  assign O_MEMORY_BUS_CLOCK       = mem_q;
  assign O_MEMORY_BUS_CLOCK_N     = ~mem_q;
  assign O_LOCALBUS_CLOCK_OUTPUTS = {lb_q, lb_q};
endmodule

// File: scc_chk.sv
// Concurrent property checker for the clock tree control block
`timescale 1ns/1ns
module scc_chk
  import scc_pkg::*;
#(
  parameter int N_PCI_OUT = 5
) (
  input wire logic                 I_CLOCK,
  input wire logic                 I_RST,
  input wire logic                 I_HOST_MODE,
  input wire logic                 I_HOST_INPUT_CLOCK,
  input wire logic                 I_AGENT_INPUT_CLOCK,
  input wire logic                 I_INPUT_HALVING_SELECT,
  input wire logic                 I_USE_HARD_CFG,
  input wire logic [CFG_W-1:0]     I_RESET_CONFIG_LOW,
  input wire logic                 O_SYNC_CLOCK_OUT,
  input wire logic [N_PCI_OUT-1:0] O_PCI_CLOCK_OUTPUTS,
  input wire logic                 O_CFG_LOADED,
  input wire logic                 O_SYSTEM_PLL_RESERVED,
  input wire logic                 O_CORE_PLL_BYPASS,
  input wire logic                 O_MEMORY_CLOCK_DOUBLE,
  input wire logic                 O_MEMORY_BUS_CLOCK,
  input wire logic                 O_MEMORY_BUS_CLOCK_N,
  input wire logic [N_UNITS-1:0]   O_UNIT_CLOCK_EN
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_pci_follows_sync: assert property (
    |O_PCI_CLOCK_OUTPUTS |-> $past(O_SYNC_CLOCK_OUT))
    else $error("pci clock high without sync clock");
  // Six settled cycles cover the two-flop pin sync plus the output stage
  a_host_sync_path: assert property (
    (I_HOST_MODE && I_INPUT_HALVING_SELECT && O_CFG_LOADED)[*6]
    |-> O_SYNC_CLOCK_OUT == $past(I_HOST_INPUT_CLOCK, 3))
    else $error("sync out does not follow host clock");
  a_agent_sync_path: assert property (
    (!I_HOST_MODE && I_INPUT_HALVING_SELECT && O_CFG_LOADED)[*6]
    |-> O_SYNC_CLOCK_OUT == $past(I_AGENT_INPUT_CLOCK, 3))
    else $error("sync out does not follow agent clock");
  a_system_pll_factor_decode: assert property (
    $rose(O_CFG_LOADED) && !$past(I_USE_HARD_CFG) |-> O_SYSTEM_PLL_RESERVED ==
      !($past(I_RESET_CONFIG_LOW[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W]) inside {[2:6]}))
    else $error("system factor reserved flag wrong");
  a_core_bypass: assert property (
    $rose(O_CFG_LOADED) && !$past(I_USE_HARD_CFG) |-> O_CORE_PLL_BYPASS ==
      ($past(I_RESET_CONFIG_LOW[CORE_LSB +: 5]) == 5'h00))
    else $error("core bypass decode wrong");
  a_cfg_frozen: assert property (
    O_CFG_LOADED && $past(O_CFG_LOADED) |-> $stable({O_SYSTEM_PLL_RESERVED,
      O_CORE_PLL_BYPASS, O_MEMORY_CLOCK_DOUBLE}))
    else $error("captured configuration changed");
  a_mem_diff: assert property (O_MEMORY_BUS_CLOCK_N != O_MEMORY_BUS_CLOCK)
    else $error("memory clock pair not complementary");
  a_mem_double: assert property (
    (O_CFG_LOADED && O_MEMORY_CLOCK_DOUBLE)[*3] |-> $changed(O_MEMORY_BUS_CLOCK))
    else $error("memory bus clock not at half of doubled rate");
  a_unit_gap: assert property (|O_UNIT_CLOCK_EN |=> O_UNIT_CLOCK_EN == '0)
    else $error("unit clock pulse stretched");
endmodule
bind scc_top scc_chk #(.N_PCI_OUT(N_PCI_OUT)) i_scc_chk (
  .I_CLOCK, .I_RST, .I_HOST_MODE, .I_HOST_INPUT_CLOCK, .I_AGENT_INPUT_CLOCK,
  .I_INPUT_HALVING_SELECT, .I_USE_HARD_CFG, .I_RESET_CONFIG_LOW, .O_SYNC_CLOCK_OUT,
  .O_PCI_CLOCK_OUTPUTS, .O_CFG_LOADED, .O_SYSTEM_PLL_RESERVED, .O_CORE_PLL_BYPASS,
  .O_MEMORY_CLOCK_DOUBLE, .O_MEMORY_BUS_CLOCK, .O_MEMORY_BUS_CLOCK_N, .O_UNIT_CLOCK_EN);

// File: scc_partner.sv
// Far-side model: host and agent input clock sources
`timescale 1ns/1ns
module scc_partner (
  input  wire logic       i_clk,
  input  wire logic       i_host_mode,
  input  wire logic [3:0] i_half,
  output logic            o_host_clk,
  output logic            o_agent_clk
);
  logic [3:0] cnt  = 4'h0;
  logic       lvl  = 1'b0;
  logic       junk = 1'b0;
  always @(posedge i_clk) begin
    cnt  <= (cnt + 4'h1 >= i_half) ? 4'h0 : cnt + 4'h1;
    lvl  <= (cnt + 4'h1 >= i_half) ? ~lvl : lvl;
    junk <= ~junk;
  end
  // Host pin grounded in agent mode; unused agent pin toggles so a stale value cannot pass
  assign o_host_clk  = i_host_mode ? lvl : 1'b0;
  assign o_agent_clk = i_host_mode ? junk : lvl;
endmodule

// File: scc_top_bench.sv
// Self-checking bench for the clock tree control block
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module scc_top_bench;
  import scc_pkg::*;
  logic       clk = 0, rst = 1, hmode = 1, hsel = 1, hard = 0;
  logic       hclk, aclk, sync, mem, loaded, sres, bypass, cres, mdbl, ldbl;
  logic       stick, mtick;
  logic [4:0] pen = 5'h00, pci, uen;
  logic [31:0] cfg = 32'h0;
  logic [1:0] lbd = 2'h0, lb;
  logic [9:0] ratio = 10'h155;
  logic [3:0] half = 4'h4, smult;
  logic [2:0] cmult;
  int         errors = 0, n_compared = 0;
  logic [6:0] core [8] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h62};
  int         cm [8] = '{2, 2, 3, 4, 5, 6, 6, 2};
  int         hp [4] = '{1, 2, 4, 1};
  logic [9:0] rt [2] = '{10'h278, 10'h027};
  int         ue [2][5] = '{'{0, 30, 20, 60, 60}, '{20, 60, 30, 0, 0}};
  wire logic [11:0] probe = {mtick, stick, uen, lb[0], mem, pci[1:0], sync};
  always #25 clk = ~clk;
  scc_partner i_scc_partner (.i_clk(clk), .i_host_mode(hmode), .i_half(half),
    .o_host_clk(hclk), .o_agent_clk(aclk));
  scc_top i_scc_top (
    .I_CLOCK(clk), .I_RST(rst), .I_CE(1'b1), .I_HOST_MODE(hmode),
    .I_HOST_INPUT_CLOCK(hclk), .I_AGENT_INPUT_CLOCK(aclk), .I_INPUT_HALVING_SELECT(hsel),
    .I_PCI_OUT_ENABLE(pen), .I_USE_HARD_CFG(hard), .I_RESET_CONFIG_LOW(cfg),
    .I_LOCALBUS_DIVIDER_FIELD(lbd), .I_UNIT_RATIO(ratio), .O_SYNC_CLOCK_OUT(sync),
    .O_PCI_CLOCK_OUTPUTS(pci), .O_CFG_LOADED(loaded), .O_SYSTEM_BUS_MULT(smult),
    .O_SYSTEM_PLL_RESERVED(sres), .O_CORE_MULT_X2(cmult), .O_CORE_PLL_BYPASS(bypass),
    .O_CORE_PLL_RESERVED(cres), .O_MEMORY_CLOCK_DOUBLE(mdbl),
    .O_LOCALBUS_CLOCK_DOUBLE(ldbl), .O_SYSTEM_BUS_TICK(stick),
    .O_MEMORY_INTERNAL_TICK(mtick),
    .O_MEMORY_BUS_CLOCK(mem), .O_MEMORY_BUS_CLOCK_N(), .O_LOCALBUS_CLOCK_OUTPUTS(lb),
    .O_UNIT_CLOCK_EN(uen));
  // Word is inverted after capture so a late re-sample shows up
  task automatic boot(input logic [31:0] c);
    @(posedge clk);
    cfg <= c;
    rst <= 1;
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (14) @(posedge clk);
    cfg <= ~c;
    @(negedge clk);
    `CHECK("loaded", 1'b1, loaded)
  endtask
  task automatic rises(input int s, input int cyc, input int e, input int tol);
    logic p;
    int   c;
    c = 0;
    p = probe[s];
    repeat (cyc) begin
      @(negedge clk);
      c += int'(probe[s] && !p);
      p = probe[s];
    end
    `CHECK($sformatf("rises%0d", s), 1'b1, (c >= e - tol && c <= e + tol))
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      boot({17'h0, core[i%8], i[3:0], 2'b00, i[1:0]});
      `CHECK("sres", (i < 2 || i > 6), sres)
      `CHECK("smult", (i < 2 || i > 6) ? 4'h0 : 4'(i), smult)
      `CHECK("cmult", 3'(cm[i%8]), cmult)
      `CHECK("bypass", (i % 8 == 0), bypass)
      `CHECK("cres", (i % 8 > 5), cres)
      `CHECK("dbl", i[1:0], {mdbl, ldbl})
    end
    @(posedge clk);
    hsel <= 0;
    boot(32'h0000_0050);
    `CHECK("smult_low", 4'hA, smult)
    @(posedge clk);
    hard <= 1;
    boot(32'h0000_0000);
    `CHECK("smult_hard", 4'(2 * HARD_CFG_DEFAULT[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W]), smult)
    `CHECK("bypass_hard", 1'b0, bypass)
    @(posedge clk);
    hard <= 0;
    hsel <= 1;
    pen <= 5'h01;
    boot(32'h0000_0040);
    rises(5, 40, 20, 1);
    rises(10, 40, 20, 1);
    rises(0, 80, 10, 1);
    rises(1, 80, 10, 1);
    rises(2, 80, 0, 0);
    @(posedge clk);
    hsel <= 0;
    pen <= 5'h02;
    repeat (8) @(posedge clk);
    rises(0, 80, 5, 1);
    rises(2, 80, 5, 1);
    rises(1, 80, 0, 0);
    @(posedge clk);
    hmode <= 0;
    hsel <= 1;
    half <= 4'h3;
    repeat (8) @(posedge clk);
    rises(0, 84, 14, 1);
    for (int b = 0; b < 2; b++) begin
      for (int d = 0; d < 4; d++) begin
        @(posedge clk);
        lbd <= d[1:0];
        boot({24'h0, 4'h4, 2'b00, b[0], b[0]});
        rises(3, 96, b ? 48 : 24, 1);
        rises(11, 96, b ? 0 : 48, 1);
        rises(4, 96, 96 / (2 * hp[d] * (2 - b)), 1);
      end
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ratio <= rt[k];
      repeat (12) @(posedge clk);
      for (int u = 0; u < 5; u++) begin
        rises(5 + u, 120, ue[k][u], 1);
      end
    end
    tally_and_finish();
  end
  // Whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
